//--- src/spfw_pin_io.sv
`timescale 1ns/1ps
// Function
// R1: Input lane activity is ignored while chip select is high.
// R2: Output bits change only on the falling serial clock edge.
// R3: Dual reads drive lanes one and zero, two bits per falling edge.
// R4: All output lanes float whenever chip select is high.
// R5: Pin is write protect only with quad off and protect bits 0,1.
// R6: Write protect pin low then blocks status register writes.
// R7: Quad enable set makes the shared pin data lane two.
// R8: Host must not use the shared pin for protection in quad mode.
// R9: Input bits are captured on the rising serial clock edge.
// R10: Chip select falling starts a frame, rising ends it.
// R11: Undriven protect pin, or pin used as data, means unprotected.
module spfw_pin_io (
  // System clock and reset
  input  wire logic                   clk,
  input  wire logic                   srst,
  // Link pins
  input  wire logic                   sck,
  input  wire logic                   cs_n,
  input  spfw_pkg::spfw_lanes_t       lane_in,
  output spfw_pkg::spfw_lanes_t       lane_out,
  output spfw_pkg::spfw_lanes_t       lane_oe_n,
  // Transmit side
  input  wire logic [7:0]             tx_byte,
  input  spfw_pkg::spfw_drive_t       drive_mode,
  input  wire logic                   tx_load,
  output logic                        tx_ack,
  // Receive side
  output logic [7:0]                  rx_byte,
  output logic                        rx_valid,
  output logic                        frame_start,
  output logic                        frame_end,
  // Protection
  input  spfw_pkg::spfw_prot_t        prot,
  input  wire logic                   status_write_req,
  output logic                        status_write_block,
  output logic                        status_write_done,
  output logic                        status_write_refused
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  spfw_pkg::spfw_rise_t  rise_r, rise_nxt;
  spfw_pkg::spfw_rkeep_t rkeep_r, rkeep_nxt;
  spfw_pkg::spfw_fall_t  fall_r, fall_nxt;
  logic                  tx_tgl_r;
  spfw_pkg::spfw_core_t  core_r, core_nxt;
  logic [3:0]            sync_q;
  logic                  wp_s;
  logic                  cs_s;
  logic                  rx_tgl_s;
  logic                  tx_tgl_s;
  logic                  hw_sel;
  logic [3:0]            lin;

  assign lin = lane_in;

  // ----------------------------------------------------------------
  // Link receive, rising edge
  // ----------------------------------------------------------------
  always_comb begin
    rise_nxt         = rise_r;
    rkeep_nxt        = rkeep_r;
    rise_nxt.rx_sr   = {rise_r.rx_sr[6:0], lin[0]};                // R9
    rise_nxt.bit_cnt = rise_r.bit_cnt + 3'h1;
    if (rise_r.bit_cnt == spfw_pkg::BIT_LAST) begin
      rkeep_nxt.rx_hold = {rise_r.rx_sr[6:0], lin[0]};
      rkeep_nxt.rx_tgl  = ~rkeep_r.rx_tgl;
    end
  end

  // Chip select high clears the frame at once, with no clock
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin                                              // R1 R10
      rise_r <= spfw_pkg::RISE_RST;
    end else begin
      rise_r <= rise_nxt;
    end
  end

  // Kept across frames so a late byte is not lost at frame end
  always_ff @(posedge sck or posedge srst) begin
    if (srst) begin
      rkeep_r <= spfw_pkg::RKEEP_RST;
    end else if (!cs_n) begin                                    // R1
      rkeep_r <= rkeep_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Link transmit, falling edge
  // ----------------------------------------------------------------
  always_comb begin
    fall_nxt = fall_r;
    if (fall_r.tx_left == spfw_pkg::TX_EMPTY) begin
      // Configuration is held stable by the core between loads
      fall_nxt.mode    = core_r.cfg.mode;
      fall_nxt.qe      = core_r.cfg.qe;
      fall_nxt.out     = spfw_pkg::spfw_chunk(core_r.cfg.data,
                                              core_r.cfg.mode);
      fall_nxt.oe_n    = spfw_pkg::spfw_oe_n(core_r.cfg.mode,
                                             core_r.cfg.qe);     // R7
      fall_nxt.tx_sr   = core_r.cfg.data
                         << spfw_pkg::spfw_step(core_r.cfg.mode);
      fall_nxt.tx_left = spfw_pkg::TX_FULL
                         - spfw_pkg::spfw_step(core_r.cfg.mode);
    end else begin
      fall_nxt.out     = spfw_pkg::spfw_chunk(fall_r.tx_sr,
                                              fall_r.mode);      // R2 R3
      fall_nxt.tx_sr   = fall_r.tx_sr
                         << spfw_pkg::spfw_step(fall_r.mode);
      fall_nxt.tx_left = fall_r.tx_left
                         - spfw_pkg::spfw_step(fall_r.mode);
    end
  end

  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin                                              // R4
      fall_r <= spfw_pkg::FALL_RST;
    end else begin
      fall_r <= fall_nxt;                                        // R2
    end
  end

  always_ff @(negedge sck or posedge srst) begin
    if (srst) begin
      tx_tgl_r <= 1'h0;
    end else if (!cs_n && fall_r.tx_left == spfw_pkg::TX_EMPTY) begin
      tx_tgl_r <= ~tx_tgl_r;
    end
  end

  assign lane_out  = fall_r.out;
  assign lane_oe_n = fall_r.oe_n;

  // ----------------------------------------------------------------
  // Crossing into the system clock
  // ----------------------------------------------------------------
  spfw_sync #(
    .W   (4),
    .RST (spfw_pkg::SYNC_RST)
  ) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({lane_in.quad_data_lane_two, cs_n,
            rkeep_r.rx_tgl, tx_tgl_r}),
    .q    (sync_q)
  );

  assign {wp_s, cs_s, rx_tgl_s, tx_tgl_s} = sync_q;

  // ----------------------------------------------------------------
  // Core side
  // ----------------------------------------------------------------
  // Quad enable frees the pin for data, so protection is off
  assign hw_sel = (prot.quad_io_enable == spfw_pkg::QE_OFF)       // R5 R8
                && (prot.status_protect_upper == spfw_pkg::HW_WP_UPPER)
                && (prot.status_protect_lower == spfw_pkg::HW_WP_LOWER);

  always_comb begin
    core_nxt             = core_r;
    core_nxt.cs_d        = cs_s;
    core_nxt.rx_tgl_d    = rx_tgl_s;
    core_nxt.tx_tgl_d    = tx_tgl_s;
    core_nxt.frame_start = core_r.cs_d & ~cs_s;                  // R10
    core_nxt.frame_end   = ~core_r.cs_d & cs_s;                  // R10
    core_nxt.rx_valid    = rx_tgl_s ^ core_r.rx_tgl_d;
    core_nxt.tx_ack      = tx_tgl_s ^ core_r.tx_tgl_d;
    if (rx_tgl_s ^ core_r.rx_tgl_d) begin
      core_nxt.rx_byte = rkeep_r.rx_hold;
    end
    if (tx_load) begin
      core_nxt.cfg = '{tx_byte, drive_mode, prot.quad_io_enable};
    end
    // Pulled-up pin reads high when undriven
    core_nxt.block      = hw_sel & ~wp_s;                        // R6 R11
    core_nxt.wr_done    = status_write_req & ~core_r.block;
    core_nxt.wr_refused = status_write_req & core_r.block;       // R6
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      core_r <= spfw_pkg::CORE_RST;
    end else begin
      core_r <= core_nxt;
    end
  end

  assign tx_ack               = core_r.tx_ack;
  assign rx_byte              = core_r.rx_byte;
  assign rx_valid             = core_r.rx_valid;
  assign frame_start          = core_r.frame_start;
  assign frame_end            = core_r.frame_end;
  assign status_write_block   = core_r.block;
  assign status_write_done    = core_r.wr_done;
  assign status_write_refused = core_r.wr_refused;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_rx_ignore_desel: assert property (                           // R1
    @(posedge clk) disable iff (srst)
    (cs_s && core_r.cs_d) [*8] |=> !rx_valid)
    else $error("byte received while deselected");

  a_single_fall_out: assert property (                           // R2
    @(negedge sck) disable iff (cs_n)
    (fall_r.tx_left != 4'h0 && fall_r.mode == spfw_pkg::SPFW_DRV_SINGLE)
    |=> lane_out.data_lane_one == $past(fall_r.tx_sr[7]))
    else $error("single lane bit wrong after falling edge");

  a_dual_two_bits: assert property (                             // R3
    @(negedge sck) disable iff (cs_n)
    (fall_r.tx_left != 4'h0 && fall_r.mode == spfw_pkg::SPFW_DRV_DUAL)
    |=> ({lane_out.data_lane_one, lane_out.data_lane_zero}
         == $past(fall_r.tx_sr[7:6])) && (lane_oe_n[1:0] == 2'h0))
    else $error("dual lanes wrong after falling edge");

  a_float_desel: assert property (                               // R4
    @(posedge clk) disable iff (srst)
    cs_n |-> (lane_oe_n == spfw_pkg::OE_ALL_OFF))
    else $error("lane driven while deselected");

  a_wp_select: assert property (                                 // R5 R6
    @(posedge clk) disable iff (srst)
    (hw_sel && !wp_s) [*2] |-> status_write_block)
    else $error("protect pin low did not block");

  a_wp_refuse: assert property (                                 // R6
    @(posedge clk) disable iff (srst)
    (status_write_req && status_write_block)
    |=> status_write_refused && !status_write_done)
    else $error("status write not refused");

  a_quad_lane_two: assert property (                             // R7
    @(negedge sck) disable iff (cs_n)
    !lane_oe_n.quad_data_lane_two |-> fall_r.qe)
    else $error("lane two driven without quad enable");

  a_no_protect: assert property (                                // R11
    @(posedge clk) disable iff (srst)
    (!hw_sel || wp_s) |=> !status_write_block)
    else $error("block without protect selection");

  a_rise_capture: assert property (                              // R9
    @(posedge sck) disable iff (cs_n)
    rise_r.bit_cnt == spfw_pkg::BIT_LAST
    |=> rkeep_r.rx_hold == {$past(rise_r.rx_sr[6:0]), $past(lin[0])})
    else $error("captured byte wrong");

  a_frame_start: assert property (                               // R10
    @(posedge clk) disable iff (srst)
    (core_r.cs_d && !cs_s) |=> frame_start ##1 !frame_start)
    else $error("frame start pulse missing");

  a_frame_end: assert property (                                 // R10
    @(posedge clk) disable iff (srst)
    (!core_r.cs_d && cs_s) |=> frame_end ##1 !frame_end)
    else $error("frame end pulse missing");

  a_quad_four_bits: assert property (                            // R7
    @(negedge sck) disable iff (cs_n)
    (fall_r.tx_left != 4'h0 && fall_r.mode == spfw_pkg::SPFW_DRV_QUAD
     && fall_r.qe)
    |=> (lane_out == $past(fall_r.tx_sr[7:4])) && (lane_oe_n == 4'h0))
    else $error("quad lanes wrong after falling edge");

  a_quad_off_float: assert property (                            // R7
    @(negedge sck) disable iff (cs_n)
    (fall_r.mode == spfw_pkg::SPFW_DRV_QUAD && !fall_r.qe)
    |-> lane_oe_n == spfw_pkg::OE_ALL_OFF)
    else $error("lanes driven in quad without enable");

  a_idle_lanes_low: assert property (                            // R4
    @(posedge clk) disable iff (srst)
    cs_n |-> lane_out == spfw_pkg::LANE_IDLE)
    else $error("lane value left while deselected");

  a_rx_hold_desel: assert property (                             // R1
    @(posedge clk) disable iff (srst)
    (cs_s && core_r.cs_d) |=> $stable(rkeep_r.rx_hold))
    else $error("receive holding changed while deselected");

  a_rx_one_cycle: assert property (                              // R9
    @(posedge clk) disable iff (srst)
    rx_valid |=> !rx_valid)
    else $error("receive strobe longer than one cycle");

  a_rx_byte_hold: assert property (                              // R9
    @(posedge clk) disable iff (srst)
    $changed(rx_byte) |-> rx_valid)
    else $error("received byte changed without strobe");

  a_write_done: assert property (                                // R11
    @(posedge clk) disable iff (srst)
    (status_write_req && !status_write_block)
    |=> status_write_done && !status_write_refused)
    else $error("status write not accepted");

  a_req_quiet: assert property (                                 // R6
    @(posedge clk) disable iff (srst)
    !status_write_req |=> !status_write_done && !status_write_refused)
    else $error("status answer without request");

endmodule : spfw_pin_io

//--- src/spfw_pkg.sv
package spfw_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int         BYTE_W      = 8;
  localparam logic [2:0] BIT_FIRST   = 3'h0;
  localparam logic [2:0] BIT_LAST    = 3'h7;
  localparam logic [3:0] TX_EMPTY    = 4'h0;
  localparam logic [3:0] TX_FULL     = 4'h8;
  localparam logic [3:0] STEP_SINGLE = 4'h1;
  localparam logic [3:0] STEP_DUAL   = 4'h2;
  localparam logic [3:0] STEP_QUAD   = 4'h4;

  // ----------------------------------------------------------------
  // Protection selection and reset values
  // ----------------------------------------------------------------
  localparam logic       QE_OFF      = 1'h0;
  localparam logic       HW_WP_UPPER = 1'h0;
  localparam logic       HW_WP_LOWER = 1'h1;
  localparam logic [3:0] OE_ALL_OFF  = 4'hF;
  localparam logic [3:0] LANE_IDLE   = 4'h0;
  // Order {wp pin, cs_n, rx toggle, tx toggle}; pins idle high
  localparam logic [3:0] SYNC_RST    = 4'hC;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPFW_DRV_OFF    = 2'h0,
    SPFW_DRV_SINGLE = 2'h1,
    SPFW_DRV_DUAL   = 2'h2,
    SPFW_DRV_QUAD   = 2'h3
  } spfw_drive_t;

  typedef struct packed {
    logic lane_three;
    logic quad_data_lane_two;
    logic data_lane_one;
    logic data_lane_zero;
  } spfw_lanes_t;

  typedef struct packed {
    logic quad_io_enable;
    logic status_protect_upper;
    logic status_protect_lower;
  } spfw_prot_t;

  typedef struct packed {
    logic [BYTE_W-1:0] data;
    spfw_drive_t       mode;
    logic              qe;
  } spfw_tx_cfg_t;

  typedef struct packed {
    logic [BYTE_W-1:0] rx_sr;
    logic [2:0]        bit_cnt;
  } spfw_rise_t;

  typedef struct packed {
    logic [BYTE_W-1:0] rx_hold;
    logic              rx_tgl;
  } spfw_rkeep_t;

  typedef struct packed {
    logic [BYTE_W-1:0] tx_sr;
    logic [3:0]        tx_left;
    spfw_drive_t       mode;
    logic              qe;
    logic [3:0]        out;
    logic [3:0]        oe_n;
  } spfw_fall_t;

  typedef struct packed {
    spfw_tx_cfg_t      cfg;
    logic              cs_d;
    logic              rx_tgl_d;
    logic              tx_tgl_d;
    logic [BYTE_W-1:0] rx_byte;
    logic              rx_valid;
    logic              tx_ack;
    logic              frame_start;
    logic              frame_end;
    logic              block;
    logic              wr_done;
    logic              wr_refused;
  } spfw_core_t;

  localparam spfw_tx_cfg_t TX_CFG_RST = '{8'h00, SPFW_DRV_OFF, 1'h0};
  localparam spfw_rise_t   RISE_RST   = '{8'h00, 3'h0};
  localparam spfw_rkeep_t  RKEEP_RST  = '{8'h00, 1'h0};
  localparam spfw_fall_t   FALL_RST   =
    '{8'h00, 4'h0, SPFW_DRV_OFF, 1'h0, 4'h0, 4'hF};
  localparam spfw_core_t   CORE_RST   =
    '{TX_CFG_RST, 1'h1, 1'h0, 1'h0, 8'h00,
      1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0};

  // ----------------------------------------------------------------
  // Lane decoding
  // ----------------------------------------------------------------
  function automatic logic [3:0] spfw_step(spfw_drive_t m);
    case (m)
      SPFW_DRV_DUAL: spfw_step = STEP_DUAL;
      SPFW_DRV_QUAD: spfw_step = STEP_QUAD;
      default:       spfw_step = STEP_SINGLE;
    endcase
  endfunction : spfw_step

  function automatic logic [3:0] spfw_chunk(logic [7:0] sr,
                                            spfw_drive_t m);
    case (m)
      SPFW_DRV_SINGLE: spfw_chunk = {2'h0, sr[7], 1'h0};
      SPFW_DRV_DUAL:   spfw_chunk = {2'h0, sr[7:6]};
      SPFW_DRV_QUAD:   spfw_chunk = sr[7:4];
      default:         spfw_chunk = LANE_IDLE;
    endcase
  endfunction : spfw_chunk

  // Quad without its enable drives nothing: lane two stays an input
  function automatic logic [3:0] spfw_oe_n(spfw_drive_t m, logic qe);
    case (m)
      SPFW_DRV_SINGLE: spfw_oe_n = 4'hD;
      SPFW_DRV_DUAL:   spfw_oe_n = 4'hC;
      SPFW_DRV_QUAD:   spfw_oe_n = qe ? 4'h0 : OE_ALL_OFF;
      default:         spfw_oe_n = OE_ALL_OFF;
    endcase
  endfunction : spfw_oe_n

endpackage : spfw_pkg

//--- src/spfw_sync.sv
`timescale 1ns/1ps
module spfw_sync #(
  parameter int         W   = 4,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // Only the second stage reads the first
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= RST;
      q      <= RST;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : spfw_sync

//--- test/spfw_host.sv
`timescale 1ns/1ps
module spfw_host (
  // Link pins driven by the host
  output logic sck,
  output logic cs_n,
  output logic mosi,
  output logic mosi_en,
  // Shared protect pin
  output logic wp_val,
  output logic wp_en
);
  int frames = 0;

  initial begin
    sck     = 1'h0;
    cs_n    = 1'h0;
    mosi    = 1'h0;
    mosi_en = 1'h0;
    wp_val  = 1'h1;
    wp_en   = 1'h0;
    // Clean rising edge clears the link state before any frame
    #1 cs_n = 1'h1;
  end

  // ----------------------------------------------------------------
  // Frames
  // ----------------------------------------------------------------
  // Mode 0; clock idles low, and only desel_clocks runs it outside frames
  task automatic frame(input logic [7:0] d, input int n, input logic en);
    frames++;
    cs_n    = 1'h0;
    mosi_en = en;
    #20;
    for (int i = 0; i < n; i++) begin
      mosi = d[7 - (i % 8)];
      #7.5 sck = 1'h1;
      #7.5 sck = 1'h0;
    end
    #20 cs_n = 1'h1;
    mosi_en = 1'h0;
  endtask : frame

  // Stray clocks while deselected must leave no trace
  task automatic desel_clocks(input int n);
    mosi_en = 1'h1;
    for (int i = 0; i < n; i++) begin
      mosi = ~mosi;
      #7.5 sck = 1'h1;
      #7.5 sck = 1'h0;
    end
    mosi_en = 1'h0;
  endtask : desel_clocks

  task automatic set_wp(input logic en, input logic v);
    wp_en  = en;
    wp_val = v;
  endtask : set_wp
endmodule : spfw_host

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic                  clk = 1'h0;
  logic                  srst;
  logic                  sck;
  logic                  cs_n;
  logic                  mosi;
  logic                  mosi_en;
  logic                  wp_val;
  logic                  wp_en;
  logic                  flip = 1'h0;
  spfw_pkg::spfw_lanes_t li;
  spfw_pkg::spfw_lanes_t lo;
  spfw_pkg::spfw_lanes_t loe;
  logic [7:0]            tx_byte;
  spfw_pkg::spfw_drive_t drive_mode;
  logic                  tx_load;
  logic                  tx_ack;
  logic [7:0]            rx_byte;
  logic                  rx_valid;
  logic                  frame_start;
  logic                  frame_end;
  spfw_pkg::spfw_prot_t  prot;
  logic                  status_write_req;
  logic                  status_write_block;
  logic                  status_write_done;
  logic                  status_write_refused;
  wire  [3:0]            oe  = loe;
  wire  [3:0]            out = lo;
  logic [3:0]            ln_cap [16];
  logic [3:0]            oe_cap [16];
  int                    ci = 0;
  int                    error_cnt = 0;
  int                    checks_done = 0;
  int                    fs_cnt = 0;
  int                    fe_cnt = 0;
  int                    ack_cnt = 0;

  always #12.5 clk = ~clk;
  always @(posedge clk) flip <= ~flip;

  // ----------------------------------------------------------------
  // Pin wires
  // ----------------------------------------------------------------
  // Released lanes toggle so stale values cannot pass; two, three pull up
  assign li = {oe[3] ? 1'h1 : out[3],
               oe[2] ? (wp_en ? wp_val : 1'h1) : out[2],
               oe[1] ? flip : out[1],
               oe[0] ? (mosi_en ? mosi : flip) : out[0]};

  always @(posedge sck) begin
    if (ci < 16) begin
      ln_cap[ci] = li;
      oe_cap[ci] = loe;
    end
    ci++;
  end

  always @(negedge clk) begin
    if (frame_start === 1'h1) fs_cnt++;
    if (frame_end === 1'h1) fe_cnt++;
    if (tx_ack === 1'h1) ack_cnt++;
  end

  spfw_host u_spfw_host (
    .sck     (sck),
    .cs_n    (cs_n),
    .mosi    (mosi),
    .mosi_en (mosi_en),
    .wp_val  (wp_val),
    .wp_en   (wp_en)
  );

  spfw_pin_io u_spfw_pin_io (
    .clk                  (clk),
    .srst                 (srst),
    .sck                  (sck),
    .cs_n                 (cs_n),
    .lane_in              (li),
    .lane_out             (lo),
    .lane_oe_n            (loe),
    .tx_byte              (tx_byte),
    .drive_mode           (drive_mode),
    .tx_load              (tx_load),
    .tx_ack               (tx_ack),
    .rx_byte              (rx_byte),
    .rx_valid             (rx_valid),
    .frame_start          (frame_start),
    .frame_end            (frame_end),
    .prot                 (prot),
    .status_write_req     (status_write_req),
    .status_write_block   (status_write_block),
    .status_write_done    (status_write_done),
    .status_write_refused (status_write_refused)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rx_expect(input logic [7:0] exp);
    int i;
    @(negedge clk);
    for (i = 0; i < 400 && rx_valid !== 1'h1; i++) @(negedge clk);
    if (i == 400) begin
      error_cnt++;
      finish_test();
    end
    chk(rx_byte, exp);
  endtask : rx_expect

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // A kept partial byte would shift junk into the next one
  task automatic t_rx();
    u_spfw_host.frame(8'h00, 3, 1'h1);
    #100;
    u_spfw_host.desel_clocks(8);
    chk(loe, 4'hF);
    fork
      u_spfw_host.frame(8'h3C, 8, 1'h1);
      rx_expect(8'h3C);
    join
    fork
      u_spfw_host.frame(8'hA5, 16, 1'h1);
      begin
        rx_expect(8'hA5);
        rx_expect(8'hA5);
      end
    join
  endtask : t_rx

  task automatic t_tx(input spfw_pkg::spfw_drive_t m, input logic qe,
                      input logic [7:0] b);
    int         st;
    logic [3:0] eoe;
    logic [3:0] ech;
    logic [7:0] s;
    int         a0;
    st  = (m == spfw_pkg::SPFW_DRV_DUAL) ? 2 :
          (m == spfw_pkg::SPFW_DRV_QUAD) ? 4 : 1;
    eoe = (m == spfw_pkg::SPFW_DRV_SINGLE) ? 4'hD :
          (m == spfw_pkg::SPFW_DRV_DUAL) ? 4'hC :
          (m == spfw_pkg::SPFW_DRV_QUAD && qe) ? 4'h0 : 4'hF;
    @(negedge clk);
    prot       = {qe, 2'h0};
    tx_byte    = b;
    drive_mode = m;
    tx_load    = 1'h1;
    @(negedge clk);
    tx_load = 1'h0;
    ci      = 0;
    a0      = ack_cnt;
    u_spfw_host.frame(8'h00, 8 / st + 1, m == spfw_pkg::SPFW_DRV_SINGLE);
    for (int k = 0; k < 8 / st; k++) begin
      s   = b << (k * st);
      ech = (st == 4) ? s[7:4] : (st == 2) ? {2'h0, s[7:6]} :
            {2'h0, s[7], 1'h0};
      chk(oe_cap[k + 1], eoe);
      chk(ln_cap[k + 1] & ~eoe, ech & ~eoe);
    end
    #1;
    chk(loe, 4'hF);
    // One slot at the first fall, one at the last
    repeat (6) @(negedge clk);
    chk(8'(ack_cnt - a0), 8'h02);
  endtask : t_tx

  task automatic t_prot();
    logic blk;
    for (int p = 0; p < 8; p++) begin
      for (int w = 0; w < 2; w++) begin
        @(negedge clk);
        prot = p[2:0];
        u_spfw_host.set_wp(w == 1 && p < 4, 1'h0);
        blk = (p == 1) && (w == 1);
        repeat (6) @(negedge clk);
        chk(status_write_block, blk);
        status_write_req = 1'h1;
        @(negedge clk);
        status_write_req = 1'h0;
        chk({status_write_refused, status_write_done}, {blk, ~blk});
      end
    end
    u_spfw_host.set_wp(1'h0, 1'h0);
  endtask : t_prot

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    srst             = 1'h0;
    tx_byte          = 8'h00;
    drive_mode       = spfw_pkg::SPFW_DRV_OFF;
    tx_load          = 1'h0;
    prot             = 3'h0;
    status_write_req = 1'h0;
    // A real rising edge so the link-side clears fire
    #1 srst = 1'h1;
    repeat (3) @(posedge clk);
    @(negedge clk) srst = 1'h0;
    repeat (4) @(negedge clk);
    #3.3;
    t_rx();
    t_tx(spfw_pkg::SPFW_DRV_SINGLE, 1'h0, 8'h96);
    t_tx(spfw_pkg::SPFW_DRV_DUAL, 1'h0, 8'hB4);
    t_tx(spfw_pkg::SPFW_DRV_QUAD, 1'h1, 8'h5A);
    t_tx(spfw_pkg::SPFW_DRV_QUAD, 1'h0, 8'h5A);
    t_tx(spfw_pkg::SPFW_DRV_OFF, 1'h0, 8'hFF);
    t_prot();
    repeat (4) @(negedge clk);
    chk(8'(fs_cnt), 8'(u_spfw_host.frames));
    chk(8'(fe_cnt), 8'(u_spfw_host.frames));
    finish_test();
  end
endmodule : tb_top
